// ---- dmacc_ext_dev.sv ----
// Outside device on an external request pin, level handshake
`default_nettype none
module dmacc_ext_dev (
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  input  wire logic  start_i,   // Raise one request
  input  wire logic  ack_low_i, // Acknowledge is active low
  input  wire logic  ack_i,     // Acknowledge pin
  output logic       req_n_o,   // Request, active low
  output logic [7:0] acks_o     // Acknowledges seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // Hold request low until acknowledged, then release high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_n_o <= 1'b1;
      acks_o  <= 8'h00;
    end else if (!req_n_o && (ack_i != ack_low_i)) begin
      req_n_o <= 1'b1;
      acks_o  <= acks_o + 8'h01;
    end else if (start_i) begin
      req_n_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- dmacc_pkg.sv ----
// Shared constants, field layouts and carrier types of the DMA channel count and control block
`default_nettype none

package dmacc_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NUM_CH      = 4;              // Channels in the block
  localparam int NUM_EXT_CH  = 2;              // Channels with external request/ack pins
  localparam int CNT_W       = 16;             // Remaining count width
  localparam int ADDR_W      = 8;              // AXI address bits decoded

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] CH_STRIDE    = 8'h10;  // Bytes between channel blocks
  localparam logic [3:0] CNT_OFS      = 4'h0;   // Remaining transfer count
  localparam logic [3:0] CTRL_OFS     = 4'h4;   // Channel control
  localparam logic [1:0] MAP_HI_ZERO  = 2'h0;   // Address bits 7:6 of mapped space

  // ==========================================================================
  // Reset values and bus answers
  // ==========================================================================
  localparam logic [15:0] CTRL_RST    = 16'h0000; // Control after reset or standby
  localparam logic [15:0] CNT_ONE     = 16'h0001; // Count value of the last unit
  localparam logic [15:0] CNT_STEP    = 16'h0001; // Decrement per unit
  localparam logic [15:0] EXT_MASK    = 16'h00E0; // Ack phase, ack polarity, detect select
  localparam logic [1:0]  RESP_OKAY   = 2'h0;     // AXI OKAY
  localparam logic [1:0]  RESP_SLVERR = 2'h2;     // AXI SLVERR for unmapped

  // ==========================================================================
  // Address step modes
  // ==========================================================================
  localparam logic [1:0] STEP_FIXED   = 2'h0;
  localparam logic [1:0] STEP_INC     = 2'h1;
  localparam logic [1:0] STEP_DEC     = 2'h2;

  // Signed address deltas
  localparam logic signed [2:0] DELTA_ZERO = 3'sh0;
  localparam logic signed [2:0] DELTA_BYTE = 3'sh1;
  localparam logic signed [2:0] DELTA_WORD = 3'sh2;

  // ==========================================================================
  // Request source codes
  // ==========================================================================
  localparam logic [3:0] RS_EXT_DUAL   = 4'h0;
  localparam logic [3:0] RS_EXT_MEM2DEV = 4'h2;
  localparam logic [3:0] RS_EXT_DEV2MEM = 4'h3;
  localparam logic [3:0] RS_SER0_RX    = 4'h4;
  localparam logic [3:0] RS_SER0_TX    = 4'h5;
  localparam logic [3:0] RS_SER1_RX    = 4'h6;
  localparam logic [3:0] RS_SER1_TX    = 4'h7;
  localparam logic [3:0] RS_TMR0      = 4'h8;
  localparam logic [3:0] RS_TMR1      = 4'h9;
  localparam logic [3:0] RS_TMR2      = 4'hA;
  localparam logic [3:0] RS_TMR3      = 4'hB;
  localparam logic [3:0] RS_AUTO      = 4'hC;
  localparam logic [3:0] RS_ADC       = 4'hD;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  // Channel control register, bit 15 down to bit 0
  typedef struct packed {
    logic [1:0] dest_step_mode;         // 15:14
    logic [1:0] src_step_mode;          // 13:12
    logic [3:0] request_source_select;  // 11:8
    logic       ack_phase_select;       // 7
    logic       ack_polarity_select;    // 6
    logic       request_detect_select;  // 5
    logic       bus_mode_select;        // 4
    logic       unit_size_select;       // 3
    logic       irq_enable;             // 2
    logic       transfer_end_flag;      // 1
    logic       channel_go;             // 0
  } dmacc_ctrl_t;

  // On-chip peripheral request lines
  typedef struct packed {
    logic serial0_rx_full_req;
    logic serial0_tx_empty_req;
    logic serial1_rx_full_req;
    logic serial1_tx_empty_req;
    logic timer0_match_a_req;
    logic timer1_match_a_req;
    logic timer2_match_a_req;
    logic timer3_match_a_req;
    logic adc_done_req;
  } dmacc_periph_req_t;

  // Completed transfer unit report
  typedef struct packed {
    logic              done;      // One-cycle pulse
    logic [1:0]        channel;   // Channel that moved the unit
    logic signed [2:0] src_delta; // Source address step
    logic signed [2:0] dst_delta; // Destination address step
  } dmacc_unit_t;

  // Address delta from a step mode and the unit size
  function automatic logic signed [2:0] step_delta(input logic [1:0] mode,
                                                   input logic       word);
    logic signed [2:0] mag;
    mag = word ? DELTA_WORD : DELTA_BYTE;
    unique case (mode)
      STEP_INC: step_delta = mag;
      STEP_DEC: step_delta = -mag;
      default:  step_delta = DELTA_ZERO;
    endcase
  endfunction

endpackage

`default_nettype wire

// ---- dmacc_req_detect.sv ----
// Per-channel request source selection and external request detection
`default_nettype none

module dmacc_req_detect
  import dmacc_pkg::*;
#(
  parameter bit HAS_EXT = 1'b1                 // Channel owns an external request pin
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire dmacc_ctrl_t       ctrl_i,       // Channel control
  input  wire logic              ext_req_n_i,  // External request pin, active low
  input  wire dmacc_periph_req_t periph_i,     // On-chip requests
  input  wire logic              take_i,       // Unit started for this channel
  output logic                   req_o,        // Channel has a request
  output logic                   single_o      // Selected mode is single address
);

  // ==========================================================================
  // External pin edge detection
  // ==========================================================================
  logic pin_prev;   // Pin one cycle ago
  logic fall_seen;  // Falling edge waiting for service
  logic ext_req;    // External request as detected

  // Previous pin level
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= ext_req_n_i;
    end
  end

  // Falling edge latch; a new edge beats the clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_seen <= 1'b0;
    end else if (pin_prev && !ext_req_n_i) begin
      fall_seen <= 1'b1;
    end else if (take_i) begin
      fall_seen <= 1'b0;
    end
  end

  // Level or edge, chosen by the detect bit
  always_comb begin
    if (!HAS_EXT) begin
      ext_req = 1'b0;
    end else if (ctrl_i.request_detect_select) begin
      ext_req = fall_seen;
    end else begin
      ext_req = !ext_req_n_i;
    end
  end

  // ==========================================================================
  // Request source select
  // ==========================================================================
  always_comb begin
    single_o = 1'b0;
    unique case (ctrl_i.request_source_select)
      RS_EXT_DUAL:    req_o = ext_req;
      RS_EXT_MEM2DEV: begin
        req_o    = ext_req;
        single_o = 1'b1;
      end
      RS_EXT_DEV2MEM: begin
        req_o    = ext_req;
        single_o = 1'b1;
      end
      RS_SER0_RX:     req_o = periph_i.serial0_rx_full_req;
      RS_SER0_TX:     req_o = periph_i.serial0_tx_empty_req;
      RS_SER1_RX:     req_o = periph_i.serial1_rx_full_req;
      RS_SER1_TX:     req_o = periph_i.serial1_tx_empty_req;
      RS_TMR0:        req_o = periph_i.timer0_match_a_req;
      RS_TMR1:        req_o = periph_i.timer1_match_a_req;
      RS_TMR2:        req_o = periph_i.timer2_match_a_req;
      RS_TMR3:        req_o = periph_i.timer3_match_a_req;
      RS_AUTO:        req_o = 1'b1;
      RS_ADC:         req_o = periph_i.adc_done_req;
      default:        req_o = 1'b0;                                       // Illegal codes
    endcase
  end

endmodule

`default_nettype wire

// ---- dmacc_sva.sv ----
// Port checker for the DMA channel count and control block
`default_nettype none
module dmacc_sva
  import dmacc_pkg::*;
(
  input wire logic        core_clk_i, rst_i, standby_i, s_axi_awvalid_i, s_axi_awready_o,
  input wire logic        s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
  input wire logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
  input wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire dmacc_unit_t unit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Bus answers and unit report
  // ==========================================================================
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("no write response");
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
    && $stable(s_axi_bresp_o)) else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read answer");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
    && $stable(s_axi_rdata_o)) else $error("read data dropped");
  a_slverr_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
    |-> s_axi_rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_done_pulse: assert property (unit_o.done |=> !unit_o.done)
    else $error("done too long");
  a_delta_idle: assert property (!unit_o.done |-> unit_o.src_delta == 3'sh0
    && unit_o.dst_delta == 3'sh0) else $error("delta outside unit");
  a_standby_quiet: assert property (standby_i [*3] |-> !unit_o.done)
    else $error("unit during standby");
endmodule
bind dmacc_top dmacc_sva i_dmacc_sva (.*);
`default_nettype wire

// ---- dmacc_tb_top.sv ----
// Register bus bench for the DMA channel count and control block
`default_nettype none
module dmacc_tb_top;
  import dmacc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, stby, awv, wv, bry, arv, rry, start, awr, wrd, bv, arr, rv, req_n, al;
  logic [7:0] awa, ara, acks;
  logic [31:0] wd, rdata;
  logic [3:0] strb;
  logic [1:0] bresp, rresp, ack;
  logic signed [2:0] exp_s, exp_d;
  dmacc_unit_t unit;
  dmacc_periph_req_t per;
  int fail_count, check_count, cyc, units;
  dmacc_top i_dmacc_top (.core_clk_i(clk), .rst_i(rst), .standby_i(stby),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
    .s_axi_rready_i(rry), .ext_request_pin_n_i({1'b1, req_n}), .ext_ack_pin_o(ack),
    .periph_req_i(per), .unit_o(unit));
  dmacc_ext_dev i_dmacc_ext_dev (.core_clk_i(clk), .rst_i(rst), .start_i(start),
    .ack_low_i(al), .ack_i(ack[0]), .req_n_o(req_n), .acks_o(acks));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard and unit report check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (unit.done === 1'b1) begin
      units <= units + 1;
      chk(32'({unit.src_delta, unit.dst_delta}), 32'({exp_s, exp_d}));
    end
    if (cyc == 3000) begin
      fail_count++;
      $display("FAIL %0t timeout", $time);
      wrap_up();
    end
  end
  task automatic kick();
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    {awa, wd, strb} <= {a, 16'h0000, d, s};
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv) bry <= 1'b0;
    end while (awv || wv || bry);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    ara <= a;
    {arv, rry} <= 2'h3;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rry <= 1'b0;
        chk(rdata, e);
        chk(32'(rresp), 32'(r));
      end
    end while (arv || rry);
  endtask
  task automatic wait_units(input int n);
    for (int i = 0; i < 300 && units < n; i++) @(posedge clk);
    chk(32'(units), 32'(n));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {stby, awv, wv, bry, arv, rry, start, al, per, awa, ara, wd, strb, exp_s, exp_d} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int n = 0; n < NUM_CH; n++) rd(8'(n * 16 + 4), 32'h0, RESP_OKAY);
    wr(8'h24, 16'hFFE2, 4'hF);
    rd(8'h24, 32'h0000FF00, RESP_OKAY);
    wr(8'h30, 16'hFFFF, 4'hF);
    wr(8'h30, 16'h0012, 4'h1);
    rd(8'h30, 32'h0000FF12, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    {exp_s, exp_d} = {3'sh2, 3'sh2};
    wr(8'h00, 16'h0002, 4'hF);
    wr(8'h04, 16'h5C09, 4'hF);
    wait_units(2);
    rd(8'h00, 32'h0, RESP_OKAY);
    rd(8'h04, 32'h00005C0B, RESP_OKAY);
    {exp_s, exp_d} = {3'sh7, 3'sh1};
    wr(8'h30, 16'h0001, 4'hF);
    wr(8'h34, 16'h6C01, 4'hF);
    wait_units(3);
    rd(8'h34, 32'h00006C03, RESP_OKAY);
    wr(8'h04, 16'h5C08, 4'hF);
    rd(8'h04, 32'h00005C08, RESP_OKAY);
    {exp_s, exp_d} = {3'sh0, 3'sh2};
    wr(8'h00, 16'h0001, 4'hF);
    wr(8'h04, 16'h5329, 4'hF);
    kick();
    wait_units(4);
    wr(8'h04, 16'h0000, 4'hF);
    {exp_s, exp_d} = '0;
    al <= 1'b1;
    wr(8'h00, 16'h0001, 4'hF);
    wr(8'h04, 16'h0041, 4'hF);
    kick();
    wait_units(5);
    chk(32'(acks), 32'h2);
    wr(8'h20, 16'h0001, 4'hF);
    wr(8'h24, 16'h0401, 4'hF);
    per.serial0_rx_full_req <= 1'b1;
    wait_units(6);
    wr(8'h14, 16'hFFE2, 4'hF);
    rd(8'h14, 32'h0000FFE0, RESP_OKAY);
    stby <= 1'b1;
    repeat (3) @(posedge clk);
    stby <= 1'b0;
    rd(8'h14, 32'h0, RESP_OKAY);
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- dmacc_top.sv ----
// DMA channel count and control: registers, request handling and unit sequencing
//
// How it works
// - Count 1 is one, 0 is 65536 transfers
// - Count register shows units still remaining
// - Count is not reset; software programs it
// - Control clears on reset and standby
// - End flag: write zero clears, one ignored
// - Ack and detect fields only on channels 0,1
// - Destination mode: fixed, increment, decrement, illegal
// - Step one for bytes, two for words
// - Destination mode ignored for memory-to-device single
// - Source mode: fixed, increment, decrement, illegal
// - Source mode ignored for device-to-memory single
// - Source select codes 0, 2, 3 external; code 1 illegal
// - Codes 4 to 13 on-chip or auto requests
// - External sources only on channels 0,1
// - Ack phase: read cycle or write cycle
// - Ack polarity: high when 0, low when 1
// - Detect bit chooses external request detection
// - Low level when 0, falling edge when 1
// - Size bit: byte or 16-bit word
// - End flag set when count reaches zero
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none

module dmacc_top
  import dmacc_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  standby_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Requests and acknowledges
  input  wire logic [NUM_EXT_CH-1:0] ext_request_pin_n_i,
  output logic [NUM_EXT_CH-1:0]      ext_ack_pin_o,
  input  wire dmacc_periph_req_t     periph_req_i,
  // Completed unit report
  output dmacc_unit_t                unit_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_READ, SEQ_WRITE} dmacc_seq_t;

  dmacc_ctrl_t      ctrl   [NUM_CH];   // Channel control registers
  logic [CNT_W-1:0] count  [NUM_CH];   // Remaining transfer counts
  logic [NUM_CH-1:0] chan_req;         // Per-channel request
  logic [NUM_CH-1:0] chan_single;      // Per-channel single-address mode
  logic [NUM_CH-1:0] chan_take;        // Unit started on channel
  logic [NUM_CH-1:0] chan_ready;       // Eligible to start a unit
  logic [NUM_CH-1:0] set_end;          // Last unit of a channel ends now
  dmacc_seq_t       seq;               // Unit sequencer state
  dmacc_seq_t       next_seq;
  logic [1:0]       cur_ch;            // Channel being served
  logic [1:0]       next_ch;
  logic             cur_single;        // Served unit is single address
  logic             next_single;
  logic             unit_end;          // Unit finishes this cycle

  // Write channel holding
  logic             aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic             w_held;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_fire;           // Both halves present, response free
  logic             wr_hit_cnt;
  logic             wr_hit_ctrl;
  logic [1:0]       wr_ch;
  logic [15:0]      wr_val;            // Old value merged with new bytes

  // ==========================================================================
  // Request detection per channel
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      dmacc_req_detect #(
        .HAS_EXT (g < NUM_EXT_CH)
      ) u_det (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .ctrl_i      (ctrl[g]),
        .ext_req_n_i ((g < NUM_EXT_CH) ? ext_request_pin_n_i[g % NUM_EXT_CH] : 1'b1),
        .periph_i    (periph_req_i),
        .take_i      (chan_take[g]),
        .req_o       (chan_req[g]),
        .single_o    (chan_single[g])
      );
      // Enabled, not ended and requesting
      assign chan_ready[g] = ctrl[g].channel_go && !ctrl[g].transfer_end_flag
                             && chan_req[g];
      // Count leaves one on the served channel: the end flag goes up
      assign set_end[g]    = unit_end && (cur_ch == 2'(g))
                             && (count[g] == CNT_ONE);
      assign chan_take[g]  = (seq == SEQ_IDLE) && (next_seq != SEQ_IDLE)
                             && (next_ch == 2'(g));
    end
  endgenerate

  // ==========================================================================
  // Unit sequencer
  // ==========================================================================
  assign unit_end = (seq == SEQ_WRITE);

  // Pick the lowest ready channel; dual address runs read then write
  always_comb begin
    next_seq    = seq;
    next_ch     = cur_ch;
    next_single = cur_single;
    unique case (seq)
      SEQ_IDLE: begin
        for (int i = NUM_CH - 1; i >= 0; i--) begin
          if (chan_ready[i] && !standby_i) begin
            next_ch     = 2'(i);
            next_single = chan_single[i];
            next_seq    = chan_single[i] ? SEQ_WRITE : SEQ_READ;
          end
        end
      end
      SEQ_READ:  next_seq = standby_i ? SEQ_IDLE : SEQ_WRITE;
      SEQ_WRITE: next_seq = SEQ_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq        <= SEQ_IDLE;
      cur_ch     <= 2'h0;
      cur_single <= 1'b0;
    end else begin
      seq        <= next_seq;
      cur_ch     <= next_ch;
      cur_single <= next_single;
    end
  end

  // Acknowledge pins follow the next phase of the served channel
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_ack_pin_o <= '0;
    end else begin
      for (int i = 0; i < NUM_EXT_CH; i++) begin
        // Read or write phase per phase bit; single address acks in write
        ext_ack_pin_o[i] <= ctrl[i].ack_polarity_select ^ ((next_ch == 2'(i))
          && ((next_seq == SEQ_READ && !ctrl[i].ack_phase_select)
          || (next_seq == SEQ_WRITE && (next_single || ctrl[i].ack_phase_select))));
      end
    end
  end

  // Completed unit report with address steps
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit_o <= '0;
    end else begin
      unit_o.done    <= unit_end;
      unit_o.channel <= cur_ch;
      if (unit_end && !(cur_single &&
          ctrl[cur_ch].request_source_select == RS_EXT_MEM2DEV)) begin
        unit_o.dst_delta <= step_delta(ctrl[cur_ch].dest_step_mode,
                                       ctrl[cur_ch].unit_size_select);
      end else begin
        unit_o.dst_delta <= DELTA_ZERO;
      end
      if (unit_end && !(cur_single &&
          ctrl[cur_ch].request_source_select == RS_EXT_DEV2MEM)) begin
        unit_o.src_delta <= step_delta(ctrl[cur_ch].src_step_mode,
                                       ctrl[cur_ch].unit_size_select);
      end else begin
        unit_o.src_delta <= DELTA_ZERO;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  assign wr_fire     = aw_held && w_held && !s_axi_bvalid_o;
  assign wr_ch       = aw_addr[5:4];
  assign wr_hit_cnt  = (aw_addr[7:6] == MAP_HI_ZERO) && (aw_addr[3:0] == CNT_OFS);
  assign wr_hit_ctrl = (aw_addr[7:6] == MAP_HI_ZERO) && (aw_addr[3:0] == CTRL_OFS);

  // Merge written byte lanes into the addressed register
  always_comb begin
    logic [15:0] old;
    old    = wr_hit_cnt ? count[wr_ch] : ctrl[wr_ch];
    wr_val = old;
    if (w_strb[0]) begin
      wr_val[7:0] = w_data[7:0];
    end
    if (w_strb[1]) begin
      wr_val[15:8] = w_data[15:8];
    end
  end

  // Address and data are taken independently and held
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready while the holding slot is empty
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      s_axi_awready_o <= !(aw_held || (s_axi_awvalid_i && s_axi_awready_o)) || wr_fire;
      s_axi_wready_o  <= !(w_held || (s_axi_wvalid_i && s_axi_wready_o)) || wr_fire;
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (wr_hit_cnt || wr_hit_ctrl) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Count and control registers
  // ==========================================================================
  // Count has no reset value; software loads it before enabling
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (wr_fire && wr_hit_cnt && wr_ch == 2'(i)) begin
        count[i] <= wr_val;
      end else if (unit_end && cur_ch == 2'(i)) begin
        count[i] <= count[i] - CNT_STEP;
      end
    end
  end

  // Control: cleared by reset and standby, end flag set beats clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl[i] <= CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (standby_i) begin
          ctrl[i] <= CTRL_RST;
        end else if (wr_fire && wr_hit_ctrl && wr_ch == 2'(i)) begin
          ctrl[i] <= (i < NUM_EXT_CH) ? wr_val : (wr_val & ~EXT_MASK);
          ctrl[i].transfer_end_flag <= set_end[i] ||
            (ctrl[i].transfer_end_flag && wr_val[1]);
        end else if (set_end[i]) begin
          ctrl[i].transfer_end_flag <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  // Address ready: low from the take until the read answer is accepted
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
    end else if (!s_axi_rvalid_o || s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // Registered read data, zero above bit 15 and for unmapped addresses
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      if (s_axi_araddr_i[7:6] == MAP_HI_ZERO && s_axi_araddr_i[3:0] == CNT_OFS) begin
        s_axi_rdata_o <= {16'h0000, count[s_axi_araddr_i[5:4]]};
        s_axi_rresp_o <= RESP_OKAY;
      end else if (s_axi_araddr_i[7:6] == MAP_HI_ZERO
                   && s_axi_araddr_i[3:0] == CTRL_OFS) begin
        s_axi_rdata_o <= {16'h0000, 16'(ctrl[s_axi_araddr_i[5:4]])};
        s_axi_rresp_o <= RESP_OKAY;
      end else begin
        s_axi_rdata_o <= '0;
        s_axi_rresp_o <= RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire
